// ==== logic/timer_quad_regs.svh ====
// Register offsets, field positions, codes and reset values of the
// quad eight-bit timer. Definitions only; included by the design files.
`ifndef TIMER_QUAD_REGS_SVH
`define TIMER_QUAD_REGS_SVH

// Byte offsets inside one channel pair; pairs sit one stride apart.
`define TQ_OFS_COUNT 8'h00
`define TQ_OFS_CONST_A 8'h04
`define TQ_OFS_CONST_B 8'h08
`define TQ_OFS_CONTROL 8'h0C
`define TQ_OFS_STATUS 8'h10
`define TQ_PAIR_STRIDE 8'h20

// Reset value of every eight-bit register.
`define TQ_RST_VAL 8'h00

// Control register field positions.
`define TQ_CKS_MSB 2
`define TQ_CLR_HI 4
`define TQ_CLR_LO 3

// Control/status register field positions.
`define TQ_BIT_MATCH_B 7
`define TQ_BIT_MATCH_A 6
`define TQ_BIT_WRAP 5
`define TQ_BIT_CAPEN 4
`define TQ_OSB_HI 3
`define TQ_OSB_LO 2
`define TQ_OSA_HI 1
`define TQ_OSA_LO 0

// Clock-select codes.
`define TQ_CKS_STOP 3'b000
`define TQ_CKS_DIV_FAST 3'b001
`define TQ_CKS_DIV_MID 3'b010
`define TQ_CKS_DIV_SLOW 3'b011
`define TQ_CKS_CASCADE 3'b100
`define TQ_CKS_EXT_RISE 3'b101
`define TQ_CKS_EXT_FALL 3'b110
`define TQ_CKS_EXT_BOTH 3'b111

// Clear-select codes.
`define TQ_CLR_NONE 2'b00
`define TQ_CLR_MATCH_A 2'b01
`define TQ_CLR_MATCH_B 2'b10
`define TQ_CLR_CAPTURE 2'b11

// Output actions, ordered so that the larger code wins.
`define TQ_ACT_HOLD 2'b00
`define TQ_ACT_LOW 2'b01
`define TQ_ACT_HIGH 2'b10
`define TQ_ACT_TOGGLE 2'b11

// Capture edge codes.
`define TQ_EDGE_RISE 2'b00
`define TQ_EDGE_FALL 2'b01
`define TQ_EDGE_BOTH 2'b10

// Prescaler ratios of the system clock.
`define TQ_DIV_FAST 8
`define TQ_DIV_MID 64
`define TQ_DIV_SLOW 8192

`endif

// ==== logic/timer_quad_pkg.sv ====
// Types shared by the quad eight-bit timer.
// Assumes the register header is compiled alongside.
package timer_quad_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [1:0] pin_act_t;
endpackage

// ==== logic/tq_edge_sync.sv ====
// Two-stage synchroniser with rising and falling edge pulses.
// Assumes the pin is asynchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
module tq_edge_sync (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Pin and edges.
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Only the second stage reads the first.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_rise = sync_q & ~prev_q; // RULE28
  assign o_fall = ~sync_q & prev_q; // RULE28
endmodule
`default_nettype wire

// ==== logic/timer_quad.sv ====
// Quad eight-bit timer: two cascadable channel pairs behind an APB slave.
// Assumes one system clock, synchronous reset and asynchronous pins.
//
// Contract
// RULE1 - Eight-bit registers, word or byte access
// RULE2 - Internal clocks are divide by 8, 64, 8192
// RULE3 - External clock counts rising, falling or both
// RULE4 - Capture pulse levels last 1.5/2.5 clocks
// RULE5 - Matches hold, clear, set or toggle pin
// RULE6 - Clear select clears on match A or B
// RULE7 - Clear select clears on capture B
// RULE8 - Capture edge rising, falling or both
// RULE9 - Match fires on increment leaving matched count
// RULE10 - Capture copies count and sets B flag
// RULE11 - Wrap flag on all ones to zero
// RULE12 - Pair cascade code makes sixteen-bit counter
// RULE13 - Upper flags sixteen-bit, lower flags byte match
// RULE14 - Pins follow sixteen-bit and byte matches
// RULE15 - Wide capture sets both B flags, upper edge
// RULE16 - Wide mode clears both bytes from upper select
// RULE17 - Upper wraps at sixteen bits, lower per byte
// RULE18 - Lower cascade code counts upper match A
// RULE19 - Second pair behaves like first pair
// RULE20 - Both cascade modes together stop the pair
// RULE21 - Wide capture fills both constant B registers
// RULE22 - Software enables capture, edge, then clock
// RULE23 - Flags clear by read one, write zero
// RULE24 - Output select codes hold, zero, one, toggle
// RULE25 - Coinciding matches take higher priority action
// RULE26 - Capture edge codes rising, falling, both
// RULE27 - No source holds count; code 100 cascades
// RULE28 - Pins synchronised and edge detected first
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "timer_quad_regs.svh"
module timer_quad
  import timer_quad_pkg::*;
#(
  parameter int DIV_FAST = `TQ_DIV_FAST,
  parameter int DIV_MID = `TQ_DIV_MID,
  parameter int DIV_SLOW = `TQ_DIV_SLOW
) (
  // Clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // APB slave.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // External clock pins, one per channel.
  input wire logic [3:0] I_EXT_CLK,
  // Capture side of the two-way pins of channels 1 and 3.
  input wire logic [1:0] I_CAPTURE_PIN,
  // Timer output pins and their active-low enables.
  output logic [3:0] O_TIMER_OUT_PIN,
  output logic [3:0] O_TIMER_OUT_PIN_OE_N
);
  localparam int DW = $clog2(DIV_SLOW);
  // Larger action code has the higher priority.
  function automatic pin_act_t merge_act(input pin_act_t a,
                                         input pin_act_t b);
    merge_act = (a > b) ? a : b; // RULE25
  endfunction
  function automatic logic apply_act(input pin_act_t act, input logic q);
    case (act)
      `TQ_ACT_LOW: apply_act = 1'b0; // RULE24
      `TQ_ACT_HIGH: apply_act = 1'b1; // RULE24
      `TQ_ACT_TOGGLE: apply_act = ~q; // RULE24
      default: apply_act = q;
    endcase
  endfunction
  // Bus decode.
  logic [7:0] ofs;
  logic pair_sel;
  logic addr_ok;
  logic wr_acc;
  logic rd_acc;
  logic [15:0] rd_pair [2];
  logic [31:0] rdata_q;
  logic [DW-1:0] div_q;
  logic tick_fast;
  logic tick_mid;
  logic tick_slow;
  logic [2:0] cks_w [4];
  logic [3:0] src_tick;
  logic [3:0] ext_rise;
  logic [3:0] ext_fall;
  logic [1:0] cap_rise;
  logic [1:0] cap_fall;

  assign ofs = {3'b000, I_PADDR[4:0]};
  assign pair_sel = I_PADDR[5];
  assign addr_ok = (I_PADDR[7:6] == 2'b00) &&
                   (ofs == `TQ_OFS_COUNT || ofs == `TQ_OFS_CONST_A ||
                    ofs == `TQ_OFS_CONST_B || ofs == `TQ_OFS_CONTROL ||
                    ofs == `TQ_OFS_STATUS);
  assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE & addr_ok;
  assign rd_acc = I_PSEL & I_PENABLE & ~I_PWRITE & addr_ok;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;
  assign O_PRDATA = rdata_q;

  // Read data is captured in the setup cycle and held for the access.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (I_PSEL & ~I_PENABLE) begin
      rdata_q <= addr_ok ? {16'h0000, rd_pair[pair_sel]} : 32'h0000_0000;
    end
  end

  // Free-running prescaler for the internal clock choices.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tick_fast = (div_q & DW'(DIV_FAST - 1)) == DW'(DIV_FAST - 1); // RULE2
  assign tick_mid = (div_q & DW'(DIV_MID - 1)) == DW'(DIV_MID - 1); // RULE2
  assign tick_slow = div_q == DW'(DIV_SLOW - 1); // RULE2

  // Per-channel pin synchronisers and clock source decode.
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_chan
      tq_edge_sync u_ext (
        .i_clk(I_CORE_CLK),
        .i_rst(I_SRST),
        .i_pin(I_EXT_CLK[c]),
        .o_rise(ext_rise[c]),
        .o_fall(ext_fall[c])
      );
      always_comb begin
        case (cks_w[c])
          `TQ_CKS_DIV_FAST: src_tick[c] = tick_fast; // RULE2
          `TQ_CKS_DIV_MID: src_tick[c] = tick_mid; // RULE2
          `TQ_CKS_DIV_SLOW: src_tick[c] = tick_slow; // RULE2
          `TQ_CKS_EXT_RISE: src_tick[c] = ext_rise[c]; // RULE3
          `TQ_CKS_EXT_FALL: src_tick[c] = ext_fall[c]; // RULE3
          `TQ_CKS_EXT_BOTH: src_tick[c] = ext_rise[c] | ext_fall[c]; // RULE3
          default: src_tick[c] = 1'b0; // RULE27
        endcase
      end
    end
  endgenerate

  // Each pair: upper channel 2p, lower channel 2p+1.
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair // RULE19
      reg8_t cnt_h_q, cnt_l_q, cra_h_q, cra_l_q, crb_h_q, crb_l_q;
      reg8_t ctl_h_q, ctl_l_q, csr_h_q, csr_l_q;
      logic [2:0] arm_h_q, arm_l_q;
      logic out_h_q, out_l_q;
      logic wide, evt, capture_enable;
      logic inc_h, inc_l, ma_h, mb_h, ma_l, mb_l;
      logic cap, clr_h, clr_l, ov_h, ov_l, carry;
      logic [1:0] edge_sel, clr_sel_h, clr_sel_l;
      logic wr_p, rd_p;
      logic [2:0] set_h, set_l, wclr_h, wclr_l;

      assign cks_w[2*p] = ctl_h_q[`TQ_CKS_MSB:0];
      assign cks_w[2*p+1] = ctl_l_q[`TQ_CKS_MSB:0];
      assign wr_p = wr_acc & (pair_sel == 1'(p));
      assign rd_p = rd_acc & (pair_sel == 1'(p));

      tq_edge_sync u_cap (
        .i_clk(I_CORE_CLK),
        .i_rst(I_SRST),
        .i_pin(I_CAPTURE_PIN[p]),
        .o_rise(cap_rise[p]),
        .o_fall(cap_fall[p])
      );

      assign wide = ctl_h_q[`TQ_CKS_MSB:0] == `TQ_CKS_CASCADE; // RULE12
      assign evt = ctl_l_q[`TQ_CKS_MSB:0] == `TQ_CKS_CASCADE; // RULE18
      assign capture_enable = csr_l_q[`TQ_BIT_CAPEN];

      // Clock pulses; both cascade modes at once produce none.
      assign inc_h = wide ? (~evt & src_tick[2*p+1]) // RULE12
                          : (~evt | ~wide) & src_tick[2*p]; // RULE20
      assign inc_l = evt ? (~wide & ma_h) : src_tick[2*p+1]; // RULE18 RULE20
      assign carry = inc_l & (cnt_l_q == 8'hFF); // RULE12

      // Matches fire on the pulse that leaves the matched count.
      assign ma_h = inc_h & (wide ? {cnt_h_q, cnt_l_q} == {cra_h_q, cra_l_q}
                                  : cnt_h_q == cra_h_q); // RULE9 RULE13
      assign mb_h = inc_h & ~(wide & capture_enable) &
                    (wide ? {cnt_h_q, cnt_l_q} == {crb_h_q, crb_l_q}
                          : cnt_h_q == crb_h_q); // RULE9 RULE13
      assign ma_l = inc_l & (cnt_l_q == cra_l_q); // RULE9 RULE13
      assign mb_l = inc_l & ~capture_enable & (cnt_l_q == crb_l_q); // RULE9 RULE13

      // Capture edge comes from the upper channel in sixteen-bit mode.
      assign edge_sel = wide ? csr_h_q[`TQ_OSB_HI:`TQ_OSB_LO]
                             : csr_l_q[`TQ_OSB_HI:`TQ_OSB_LO]; // RULE15
      always_comb begin
        case (edge_sel)
          `TQ_EDGE_RISE: cap = capture_enable & cap_rise[p]; // RULE8 RULE26
          `TQ_EDGE_FALL: cap = capture_enable & cap_fall[p]; // RULE8 RULE26
          `TQ_EDGE_BOTH: cap = capture_enable & (cap_rise[p] | cap_fall[p]); // RULE26
          default: cap = 1'b0;
        endcase
      end

      // Counter clearing.
      assign clr_sel_h = ctl_h_q[`TQ_CLR_HI:`TQ_CLR_LO];
      assign clr_sel_l = ctl_l_q[`TQ_CLR_HI:`TQ_CLR_LO];
      assign clr_h = (clr_sel_h == `TQ_CLR_MATCH_A && ma_h) || // RULE6
                     (clr_sel_h == `TQ_CLR_MATCH_B && mb_h) || // RULE6
                     (clr_sel_h == `TQ_CLR_CAPTURE && cap && wide); // RULE7
      assign clr_l = wide ? clr_h : // RULE16
                     (clr_sel_l == `TQ_CLR_MATCH_A && ma_l) || // RULE6
                     (clr_sel_l == `TQ_CLR_MATCH_B && mb_l) || // RULE6
                     (clr_sel_l == `TQ_CLR_CAPTURE && cap); // RULE7

      // Wrap detection.
      assign ov_h = wide ? carry & (cnt_h_q == 8'hFF) // RULE17
                         : inc_h & (cnt_h_q == 8'hFF); // RULE11
      assign ov_l = carry; // RULE11 RULE17

      // Counters: clear beats a write, a write beats an increment.
      always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
          cnt_h_q <= `TQ_RST_VAL;
        end else if (clr_h) begin
          cnt_h_q <= 8'h00; // RULE6 RULE16
        end else if (wr_p && ofs == `TQ_OFS_COUNT && I_PSTRB[1]) begin
          cnt_h_q <= I_PWDATA[15:8]; // RULE1
        end else if (wide ? carry : inc_h) begin
          cnt_h_q <= cnt_h_q + 8'h01; // RULE12
        end
      end

      always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
          cnt_l_q <= `TQ_RST_VAL;
        end else if (clr_l) begin
          cnt_l_q <= 8'h00; // RULE6 RULE7
        end else if (wr_p && ofs == `TQ_OFS_COUNT && I_PSTRB[0]) begin
          cnt_l_q <= I_PWDATA[7:0]; // RULE1
        end else if (inc_l) begin
          cnt_l_q <= cnt_l_q + 8'h01; // RULE18
        end
      end

      // Constant and control registers; a capture beats a write to constant B.
      always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
          cra_h_q <= `TQ_RST_VAL;
          cra_l_q <= `TQ_RST_VAL;
          ctl_h_q <= `TQ_RST_VAL;
          ctl_l_q <= `TQ_RST_VAL;
        end else if (wr_p) begin
          if (ofs == `TQ_OFS_CONST_A && I_PSTRB[1]) cra_h_q <= I_PWDATA[15:8];
          if (ofs == `TQ_OFS_CONST_A && I_PSTRB[0]) cra_l_q <= I_PWDATA[7:0];
          if (ofs == `TQ_OFS_CONTROL && I_PSTRB[1]) begin
            ctl_h_q <= {3'b000, I_PWDATA[`TQ_CLR_HI+8:8]}; // RULE1
          end
          if (ofs == `TQ_OFS_CONTROL && I_PSTRB[0]) begin
            ctl_l_q <= {3'b000, I_PWDATA[`TQ_CLR_HI:0]}; // RULE1
          end
        end
      end

      always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
          crb_h_q <= `TQ_RST_VAL;
        end else if (cap && wide) begin
          crb_h_q <= cnt_h_q; // RULE21
        end else if (wr_p && ofs == `TQ_OFS_CONST_B && I_PSTRB[1]) begin
          crb_h_q <= I_PWDATA[15:8];
        end
      end

      always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
          crb_l_q <= `TQ_RST_VAL;
        end else if (cap) begin
          crb_l_q <= cnt_l_q; // RULE10 RULE21
        end else if (wr_p && ofs == `TQ_OFS_CONST_B && I_PSTRB[0]) begin
          crb_l_q <= I_PWDATA[7:0];
        end
      end

      // Flag events in bit order {match B, match A, wrap}.
      assign set_h = {mb_h | (cap & wide), ma_h, ov_h}; // RULE13 RULE15
      assign set_l = {mb_l | cap, ma_l, ov_l}; // RULE10 RULE15
      assign wclr_h = (wr_p && ofs == `TQ_OFS_STATUS && I_PSTRB[1]) ?
                      arm_h_q & ~I_PWDATA[15:13] : 3'b000; // RULE23
      assign wclr_l = (wr_p && ofs == `TQ_OFS_STATUS && I_PSTRB[0]) ?
                      arm_l_q & ~I_PWDATA[7:5] : 3'b000; // RULE23

      // A status read arms every flag that was seen as one.
      always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
          arm_h_q <= 3'b000;
          arm_l_q <= 3'b000;
        end else if (rd_p && ofs == `TQ_OFS_STATUS) begin
          arm_h_q <= rdata_q[15:13]; // RULE23
          arm_l_q <= rdata_q[7:5]; // RULE23
        end else if (wr_p && ofs == `TQ_OFS_STATUS) begin
          if (I_PSTRB[1]) arm_h_q <= 3'b000;
          if (I_PSTRB[0]) arm_l_q <= 3'b000;
        end
      end

      // Status registers; a flag event wins over a clear.
      always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
          csr_h_q <= `TQ_RST_VAL;
          csr_l_q <= `TQ_RST_VAL;
        end else begin
          csr_h_q[7:5] <= (csr_h_q[7:5] & ~wclr_h) | set_h; // RULE23
          csr_l_q[7:5] <= (csr_l_q[7:5] & ~wclr_l) | set_l; // RULE23
          if (wr_p && ofs == `TQ_OFS_STATUS && I_PSTRB[1]) begin
            csr_h_q[4:0] <= I_PWDATA[12:8];
          end
          if (wr_p && ofs == `TQ_OFS_STATUS && I_PSTRB[0]) begin
            csr_l_q[4:0] <= I_PWDATA[4:0];
          end
        end
      end

      // Output pins react to the matches of their own channel.
      always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
          out_h_q <= 1'b0;
          out_l_q <= 1'b0;
        end else begin
          out_h_q <= apply_act(merge_act(
            ma_h ? csr_h_q[`TQ_OSA_HI:`TQ_OSA_LO] : `TQ_ACT_HOLD,
            mb_h ? csr_h_q[`TQ_OSB_HI:`TQ_OSB_LO] : `TQ_ACT_HOLD),
            out_h_q); // RULE5 RULE14 RULE25
          out_l_q <= apply_act(merge_act(
            ma_l ? csr_l_q[`TQ_OSA_HI:`TQ_OSA_LO] : `TQ_ACT_HOLD,
            (mb_l & ~capture_enable) ? csr_l_q[`TQ_OSB_HI:`TQ_OSB_LO] : `TQ_ACT_HOLD),
            out_l_q); // RULE5 RULE14 RULE25
        end
      end

      assign O_TIMER_OUT_PIN[2*p] = out_h_q;
      assign O_TIMER_OUT_PIN[2*p+1] = out_l_q;
      assign O_TIMER_OUT_PIN_OE_N[2*p] = csr_h_q[3:0] == 4'h0; // RULE24
      assign O_TIMER_OUT_PIN_OE_N[2*p+1] = capture_enable | (csr_l_q[3:0] == 4'h0);

      // Read view: upper channel in the high byte.
      always_comb begin
        case (ofs)
          `TQ_OFS_COUNT: rd_pair[p] = {cnt_h_q, cnt_l_q}; // RULE1
          `TQ_OFS_CONST_A: rd_pair[p] = {cra_h_q, cra_l_q};
          `TQ_OFS_CONST_B: rd_pair[p] = {crb_h_q, crb_l_q};
          `TQ_OFS_CONTROL: rd_pair[p] = {ctl_h_q, ctl_l_q};
          `TQ_OFS_STATUS: rd_pair[p] = {csr_h_q, csr_l_q};
          default: rd_pair[p] = 16'h0000;
        endcase
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== dv/timer_quad_asserts.sv ====
// Port checker for the quad eight-bit timer, bound to timer_quad.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module timer_quad_asserts (
  // Clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  // Register bus.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Timer pins.
  input wire logic [3:0] O_TIMER_OUT_PIN,
  input wire logic [3:0] O_TIMER_OUT_PIN_OE_N
);
  logic acc;
  logic mapped;
  logic aligned;
  assign acc = I_PSEL && I_PENABLE;
  assign aligned = I_PADDR[1:0] == 2'b00;
  assign mapped = I_PADDR[7:6] == 2'b00 && I_PADDR[4:2] <= 3'd4;
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SRST);
  ready_always_a: assert property (
    I_PSEL |-> O_PREADY) else $error("ready low in a transfer");
  err_access_a: assert property (
    O_PSLVERR |-> acc) else $error("error outside access phase");
  err_map_a: assert property (
    acc && aligned |-> O_PSLVERR == !mapped)
    else $error("error flag does not match the map");
  rdata_upper_a: assert property (
    acc |-> O_PRDATA[31:16] == 16'h0000) else $error("upper data not zero");
  bad_read_a: assert property (
    acc && aligned && !I_PWRITE && !mapped |-> O_PRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (
    acc |=> $stable(O_PRDATA)) else $error("read data moved");
  rst_quiet_a: assert property (
    $fell(I_SRST) |-> O_TIMER_OUT_PIN == 4'h0 &&
    O_TIMER_OUT_PIN_OE_N == 4'hF && O_PRDATA == 32'h0000_0000)
    else $error("pins not idle after reset");
  pin0_quiet_a: assert property (
    !$past(I_SRST) && $past(O_TIMER_OUT_PIN_OE_N[0]) &&
    O_TIMER_OUT_PIN_OE_N[0] |-> $stable(O_TIMER_OUT_PIN[0]))
    else $error("disabled pin zero moved");
  pin2_quiet_a: assert property (
    !$past(I_SRST) && $past(O_TIMER_OUT_PIN_OE_N[2]) &&
    O_TIMER_OUT_PIN_OE_N[2] |-> $stable(O_TIMER_OUT_PIN[2]))
    else $error("disabled pin two moved");
  cover property (acc && I_PWRITE);
  cover property (O_PSLVERR);
  cover property ($changed(O_TIMER_OUT_PIN[1]));
endmodule
bind timer_quad timer_quad_asserts i_chk (
  .I_CORE_CLK(I_CORE_CLK),
  .I_SRST(I_SRST),
  .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE),
  .I_PADDR(I_PADDR),
  .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR),
  .O_TIMER_OUT_PIN(O_TIMER_OUT_PIN),
  .O_TIMER_OUT_PIN_OE_N(O_TIMER_OUT_PIN_OE_N)
);
`default_nettype wire

// ==== dv/tq_cpu_model.sv ====
// Bus master model standing in for the processor.
// Assumes the bench calls xfer and the slave answers with ready.
`timescale 1ns/1ns
`default_nettype none
module tq_cpu_model (
  // Clock.
  input wire logic i_clk,
  // Bus master side.
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  // Wait limit ran out.
  output logic o_hung
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
    o_pstrb = 4'h0;
    o_hung = 1'b0;
  end
  // One transfer; the request holds until ready is seen at an edge or 64 edges pass.
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [15:0] v, input logic [3:0] s,
      output logic [15:0] rd, output logic err);
    int n;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= {16'h0000, v};
    o_pstrb <= s;
    @(posedge i_clk);
    o_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 64);
    if (i_pready !== 1'b1) begin
      o_hung <= 1'b1;
    end
    rd = i_prdata[15:0];
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the quad eight-bit timer.
// Assumes the design, its header and the bus model compile first.
`timescale 1ns/1ns
`default_nettype none
`include "timer_quad_regs.svh"
`define CHK(n, e, g) check(n, 16'(e), 16'(g));
module testbench;
  localparam int SLOW = 64;
  localparam logic [7:0] CNT = `TQ_OFS_COUNT;
  localparam logic [7:0] CA = `TQ_OFS_CONST_A;
  localparam logic [7:0] CB = `TQ_OFS_CONST_B;
  localparam logic [7:0] CTL = `TQ_OFS_CONTROL;
  localparam logic [7:0] STA = `TQ_OFS_STATUS;
  localparam logic [7:0] P1 = `TQ_PAIR_STRIDE;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [15:0] d;
    logic [3:0] s;
    logic [15:0] e;
    logic err;
  } row_t;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, hung;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, ext_clk, pin, oe_n;
  logic [1:0] cap;
  logic [15:0] d, d0;
  logic er;
  int n_errors = 0;
  int comparisons = 0;
  int t;
  row_t rows [10];
  logic [15:0] acts [4] = '{16'h0500, 16'h0601, 16'h0100, 16'h0901};
  timer_quad #(.DIV_SLOW(SLOW)) i_dut (
    .I_CORE_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_EXT_CLK(ext_clk), .I_CAPTURE_PIN(cap),
    .O_TIMER_OUT_PIN(pin), .O_TIMER_OUT_PIN_OE_N(oe_n));
  tq_cpu_model i_cpu (
    .i_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb),
    .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
    .o_hung(hung));
  task automatic check(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v, logic [3:0] s);
    i_cpu.xfer(1'b1, a, v, s, d, er);
  endtask
  task automatic rd(logic [7:0] a);
    i_cpu.xfer(1'b0, a, 16'h0000, 4'h0, d, er);
  endtask
  task automatic rate(logic [7:0] a, int cyc);
    rd(a);
    d0 = d;
    repeat (cyc - 3) @(posedge clk);
    rd(a);
  endtask
  task automatic pulses(int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      ext_clk[1] <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clk[1] <= 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_pin(output int n);
    logic p;
    p = pin[1];
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pin[1] === p && n < 200);
    if (n >= 200) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic arm();
    wr(P1 + CNT, 16'h0040, 4'h1);
    wr(P1 + CB, 16'h0000, 4'h1);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge hung) begin
    n_errors++;
    complete_run();
  end
  initial begin
    srst = 1'b1;
    ext_clk = 4'h0;
    cap = 2'b00;
    rows = '{'{1'b0, CNT, 16'h0, 4'h0, 16'h0000, 1'b0},
      '{1'b0, STA, 16'h0, 4'h0, 16'h0000, 1'b0},
      '{1'b0, P1 + STA, 16'h0, 4'h0, 16'h0000, 1'b0},
      '{1'b1, CA, 16'h1234, 4'h3, 16'h1234, 1'b0},
      '{1'b1, CA, 16'hAB00, 4'h2, 16'hAB34, 1'b0},
      '{1'b1, CA, 16'h0056, 4'h1, 16'hAB56, 1'b0},
      '{1'b1, P1 + CB, 16'h5AA5, 4'h3, 16'h5AA5, 1'b0},
      '{1'b1, CTL, 16'hE0E0, 4'h3, 16'h0000, 1'b0},
      '{1'b1, 8'h14, 16'hFFFF, 4'h3, 16'h0000, 1'b1},
      '{1'b1, 8'h40, 16'hFFFF, 4'h3, 16'h0000, 1'b1}};
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d, rows[i].s);
        `CHK("write error", rows[i].err, er)
      end
      rd(rows[i].a);
      `CHK("read data", rows[i].e, d)
      `CHK("read error", rows[i].err, er)
    end
    for (int k = 1; k < 4; k++) begin
      wr(CTL, 16'(k), 4'h1);
      rate(CNT, 10 * ((k == 1) ? `TQ_DIV_FAST : SLOW));
      `CHK("divided step", 10, 8'(d - d0))
    end
    for (int k = 5; k < 8; k++) begin
      wr(CTL, 16'(k), 4'h1);
      rd(CNT);
      d0 = d;
      pulses(4);
      rd(CNT);
      `CHK("external step", (k == 7) ? 8 : 4, 8'(d - d0))
    end
    wr(CTL, 16'h0000, 4'h1);
    wr(CNT, 16'h0000, 4'h1);
    wr(CA, 16'h0003, 4'h1);
    wr(STA, 16'h0003, 4'h1);
    wr(CTL, 16'h0009, 4'h1);
    wait_pin(t);
    wait_pin(t);
    `CHK("toggle period", 32, t)
    wr(CTL, 16'h0000, 4'h1);
    wr(STA, 16'h0003, 4'h1);
    rd(STA);
    `CHK("flag kept", 1, d[6])
    wr(STA, 16'h0003, 4'h1);
    rd(STA);
    `CHK("flag cleared", 0, d[6])
    wr(CB, 16'h0003, 4'h1);
    wr(CTL, 16'h0009, 4'h1);
    foreach (acts[i]) begin
      wr(STA, {8'h00, acts[i][15:8]}, 4'h1);
      repeat (40) @(posedge clk);
      `CHK("pin level", acts[i][0], pin[1])
      `CHK("pin enable", 0, oe_n[1])
    end
    wr(CTL, 16'h0001, 4'h1);
    wr(CNT, 16'h00FE, 4'h1);
    repeat (40) @(posedge clk);
    rd(STA);
    `CHK("byte wrap", 1, d[5])
    rd(STA);
    wr(STA, 16'h0000, 4'h3);
    wr(CA, 16'h0105, 4'h3);
    wr(CNT, 16'h00FE, 4'h3);
    wr(CTL, 16'h0C09, 4'h3);
    repeat (120) @(posedge clk);
    rd(CNT);
    `CHK("wide clear", 1, d > 16'h0005 && d < 16'h0100)
    rd(STA);
    `CHK("wide flags", 16'h4060, d & 16'h6060)
    wr(CTL, 16'h0401, 4'h3);
    wr(CNT, 16'hFFFE, 4'h3);
    repeat (40) @(posedge clk);
    rd(STA);
    `CHK("wide wrap", 1, d[13])
    wr(P1 + CA, 16'h0100, 4'h3);
    wr(P1 + CNT, 16'h0000, 4'h3);
    wr(P1 + CTL, 16'h0904, 4'h3);
    rate(P1 + CNT, 160);
    `CHK("event step", 10, 8'(d - d0))
    wr(P1 + CTL, 16'h0000, 4'h3);
    for (int e = 0; e < 3; e++) begin
      wr(P1 + STA, 16'h0010 | 16'(e << 2), 4'h1);
      wr(P1 + CTL, 16'h0018, 4'h1);
      arm();
      cap[1] <= 1'b1;
      repeat (8) @(posedge clk);
      rd(P1 + CB);
      `CHK("rise capture", (e != 1) ? 8'h40 : 8'h00, d[7:0])
      rd(P1 + CNT);
      `CHK("capture clear", (e != 1) ? 8'h00 : 8'h40, d[7:0])
      arm();
      cap[1] <= 1'b0;
      repeat (8) @(posedge clk);
      rd(P1 + CB);
      `CHK("fall capture", (e != 0) ? 8'h40 : 8'h00, d[7:0])
    end
    rd(P1 + STA);
    `CHK("capture flag", 1, d[7])
    `CHK("capture pin off", 1, oe_n[3])
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(STA);
    `CHK("status after reset", 16'h0000, d)
    rd(P1 + CB);
    `CHK("capture after reset", 16'h0000, d)
    complete_run();
  end
endmodule
`default_nettype wire
